// ---- rtl/pmsr_status_regs.sv ----
// status and telemetry register bank of the power supervisor
`include "pmsr_cfg.svh"
module pmsr_status_regs #(
    parameter int CHANNELS = 8,
    parameter int PAGE_W   = 3
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // read port
    input  wire pmsr_pkg::pmsr_sel_t  read_sel,
    input  wire logic [PAGE_W-1:0]    page,
    output logic [15:0]               read_data,
    // flag clearing
    input  wire logic                 clear_faults,
    input  wire logic [CHANNELS-1:0]  channel_on_cmd,
    // input and temperature status, bits 7..3 and 7..4
    input  wire logic [4:0]           input_evt,
    input  wire logic [3:0]           temp_evt,
    // communication events
    input  wire logic                 bad_command,
    input  wire logic                 bad_data,
    input  wire logic                 extra_byte,
    input  wire logic                 extra_byte_pec_ok,
    input  wire logic                 memory_fault,
    input  wire logic                 malformed_txn,
    // per channel vendor events, then global input-enable off and watchdog events
    input  wire logic [CHANNELS-1:0]  discharge_evt,
    input  wire logic [CHANNELS-1:0]  fault1_evt,
    input  wire logic [CHANNELS-1:0]  fault0_evt,
    input  wire logic [CHANNELS-1:0]  servo_reached,
    input  wire logic [CHANNELS-1:0]  dac_drive_pin,
    input  wire logic [CHANNELS-1:0]  dac_saturated_evt,
    input  wire logic                 vinen_faulted_off,
    input  wire logic                 watchdog_evt,
    // telemetry samples
    input  wire logic                 vin_valid,
    input  wire logic [15:0]          vin_sample,
    input  wire logic                 vout_valid,
    input  wire logic [PAGE_W-1:0]    vout_channel,
    input  wire logic [15:0]          vout_sample,
    input  wire logic                 temp_valid,
    input  wire logic [15:0]          temp_sample,
    input  wire logic [CHANNELS-1:0]  hires_cfg,
    // outputs
    output logic [CHANNELS-1:0]       hires_active,
    output logic                      alert_out_n
);
    import pmsr_pkg::*;

    logic [7:0]  input_flags;
    logic [7:0]  temp_flags;
    logic [7:0]  comm_flags;
    logic [7:0]  vendor_flags [CHANNELS];
    logic [15:0] vin_word;
    logic [15:0] vout_word [CHANNELS];
    logic [15:0] temp_word;
    logic [7:0]  vendor_view;
    logic        any_alert;
    logic [15:0] next_read_data;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] sticky_next(input logic [7:0] cur,
                                                input logic [7:0] evt,
                                                input logic       clr);
        sticky_next = (clr ? 8'h00 : cur) | evt;
    endfunction

    // ************************************************************
    // input, temperature and comm flags
    // ************************************************************
    // input flags, low bits zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            input_flags <= `PMSR_FLAG_RESET;
        end else begin
            input_flags <= sticky_next(input_flags, {input_evt, 3'h0}, clear_faults);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            temp_flags <= `PMSR_FLAG_RESET;
        end else begin
            temp_flags <= sticky_next(temp_flags, {temp_evt, 4'h0}, clear_faults);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            comm_flags <= `PMSR_FLAG_RESET;
        end else begin
            comm_flags <= sticky_next(comm_flags,
                                      {bad_command, bad_data,
                                       extra_byte & ~extra_byte_pec_ok,
                                       memory_fault, 2'h0, malformed_txn, 1'h0},
                                      clear_faults);
        end
    end

    // ************************************************************
    // vendor flags
    // ************************************************************
    // sticky per channel
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < CHANNELS; i++) begin
                vendor_flags[i] <= `PMSR_FLAG_RESET;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                vendor_flags[i] <= sticky_next(vendor_flags[i] & `PMSR_STICKY_MASK,
                                               {discharge_evt[i], fault1_evt[i],
                                                fault0_evt[i], 2'h0,
                                                dac_saturated_evt[i], 1'h0,
                                                watchdog_evt},
                                               clear_faults | channel_on_cmd[i])
                                   & `PMSR_STICKY_MASK;
            end
        end
    end

    always_comb begin
        vendor_view = vendor_flags[page] & ~`PMSR_GLOBAL_MASK;
        vendor_view[`PMSR_VENDOR_WATCHDOG]  = vendor_flags[0][`PMSR_VENDOR_WATCHDOG];
        vendor_view[`PMSR_VENDOR_VINEN_OFF] = vinen_faulted_off;
        vendor_view[`PMSR_VENDOR_SERVO]     = servo_reached[page];
        vendor_view[`PMSR_VENDOR_DAC]       = dac_drive_pin[page];
    end

    always_comb begin
        any_alert = 1'b0;
        for (int i = 0; i < CHANNELS; i++) begin
            any_alert = any_alert | (|(vendor_flags[i] & `PMSR_ALERT_MASK));
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            alert_out_n <= 1'b1;
        end else begin
            alert_out_n <= ~any_alert;
        end
    end

    // ************************************************************
    // telemetry
    // ************************************************************
    // hi-res honoured on odd channels only
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            hires_active[i] = hires_cfg[i] & (i % 2 == 1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            vin_word  <= `PMSR_WORD_RESET;
            temp_word <= `PMSR_WORD_RESET;
        end else begin
            if (vin_valid) begin
                vin_word <= vin_sample;
            end
            if (temp_valid) begin
                temp_word <= temp_sample;
            end
        end
    end

    // per channel output sample, format set by the converter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < CHANNELS; i++) begin
                vout_word[i] <= `PMSR_WORD_RESET;
            end
        end else if (vout_valid) begin
            vout_word[vout_channel] <= vout_sample;
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    // reads only select, never clear
    always_comb begin
        case (read_sel)
            PMSR_SEL_INPUT:     next_read_data = {8'h00, input_flags};
            PMSR_SEL_TEMP:      next_read_data = {8'h00, temp_flags};
            PMSR_SEL_COMM:      next_read_data = {8'h00, comm_flags};
            PMSR_SEL_VENDOR:    next_read_data = {8'h00, vendor_view};
            PMSR_SEL_VIN:       next_read_data = vin_word;
            PMSR_SEL_VOUT:      next_read_data = vout_word[page];
            PMSR_SEL_TEMP_READ: next_read_data = temp_word;
            default:            next_read_data = {8'h00, `PMSR_REVISION_CODE};
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            read_data <= `PMSR_WORD_RESET;
        end else begin
            read_data <= next_read_data;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    AST_INPUT_LOW_ZERO: assert property (@(posedge core_clk) disable iff (reset)
        input_flags[2:0] == 3'h0) else $error("input low bits set");
    AST_TEMP_LOW_ZERO: assert property (@(posedge core_clk) disable iff (reset)
        temp_flags[3:0] == 4'h0) else $error("temperature low bits set");
    AST_COMM_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (reset)
        {comm_flags[3:2], comm_flags[0]} == 3'h0) else $error("comm reserved set");
    AST_INPUT_SET: assert property (@(posedge core_clk) disable iff (reset)
        input_evt[4] |=> input_flags[7]) else $error("input ov lost");
    AST_TEMP_SET: assert property (@(posedge core_clk) disable iff (reset)
        temp_evt[0] |=> temp_flags[4]) else $error("ut fault lost");
    AST_CMD_SET: assert property (@(posedge core_clk) disable iff (reset)
        bad_command |=> comm_flags[7]) else $error("cmd fault lost");
    AST_PEC_OK: assert property (@(posedge core_clk) disable iff (reset)
        extra_byte && extra_byte_pec_ok && clear_faults |=> !comm_flags[5])
        else $error("matching check byte flagged");
    AST_MEM_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
        clear_faults && !memory_fault |=> !comm_flags[4]) else $error("memory not cleared");
    AST_MALFORMED: assert property (@(posedge core_clk) disable iff (reset)
        malformed_txn |=> comm_flags[1]) else $error("malformed lost");
    AST_STICKY_HOLD: assert property (@(posedge core_clk) disable iff (reset)
        vendor_flags[0][`PMSR_VENDOR_DISCHARGE] && !clear_faults && !channel_on_cmd[0]
        |=> vendor_flags[0][`PMSR_VENDOR_DISCHARGE]) else $error("sticky dropped");
    AST_ALERT: assert property (@(posedge core_clk) disable iff (reset)
        watchdog_evt |=> ##1 !alert_out_n) else $error("alert not low");
    AST_REVISION: assert property (@(posedge core_clk) disable iff (reset)
        read_sel == PMSR_SEL_REVISION |=> read_data == {8'h00, `PMSR_REVISION_CODE})
        else $error("revision wrong");
    AST_VIN_READ: assert property (@(posedge core_clk) disable iff (reset)
        vin_valid ##1 read_sel == PMSR_SEL_VIN && !vin_valid |=> read_data == $past(vin_sample, 2))
        else $error("vin stale");

    // ************************************************************
    // status bit setting
    // ************************************************************
    AST_INPUT_OV_WARN: assert property (@(posedge core_clk) disable iff (reset)
        input_evt[3] |=> input_flags[6]) else $error("input ov warn lost");
    AST_INPUT_UV_WARN: assert property (@(posedge core_clk) disable iff (reset)
        input_evt[2] |=> input_flags[5]) else $error("input uv warn lost");
    AST_INPUT_UV_FAULT: assert property (@(posedge core_clk) disable iff (reset)
        input_evt[1] |=> input_flags[4]) else $error("input uv fault lost");
    AST_INPUT_OFF: assert property (@(posedge core_clk) disable iff (reset)
        input_evt[0] |=> input_flags[3]) else $error("input off lost");
    AST_TEMP_OT_FAULT: assert property (@(posedge core_clk) disable iff (reset)
        temp_evt[3] |=> temp_flags[7]) else $error("ot fault lost");
    AST_TEMP_OT_WARN: assert property (@(posedge core_clk) disable iff (reset)
        temp_evt[2] |=> temp_flags[6]) else $error("ot warn lost");
    AST_TEMP_UT_WARN: assert property (@(posedge core_clk) disable iff (reset)
        temp_evt[1] |=> temp_flags[5]) else $error("ut warn lost");
    AST_DATA_SET: assert property (@(posedge core_clk) disable iff (reset)
        bad_data |=> comm_flags[6]) else $error("data fault lost");
    AST_PEC_SET: assert property (@(posedge core_clk) disable iff (reset)
        extra_byte && !extra_byte_pec_ok |=> comm_flags[5]) else $error("extra byte lost");
    AST_PEC_SKIP: assert property (@(posedge core_clk) disable iff (reset)
        !comm_flags[5] && extra_byte && extra_byte_pec_ok |=> !comm_flags[5])
        else $error("check byte set flag");
    AST_MEM_SET: assert property (@(posedge core_clk) disable iff (reset)
        memory_fault |=> comm_flags[4]) else $error("memory fault lost");

    // ************************************************************
    // clear and hold
    // ************************************************************
    AST_INPUT_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
        clear_faults && input_evt == 5'h00 |=> input_flags == 8'h00) else $error("input kept");
    AST_TEMP_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
        clear_faults && temp_evt == 4'h0 |=> temp_flags == 8'h00) else $error("temp kept");
    AST_CML_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
        clear_faults && !bad_command && !bad_data |=> comm_flags[7:6] == 2'h0)
        else $error("comm kept");
    AST_INPUT_HOLD: assert property (@(posedge core_clk) disable iff (reset)
        !clear_faults |=> (input_flags & $past(input_flags)) == $past(input_flags))
        else $error("input flag dropped");
    AST_TEMP_HOLD: assert property (@(posedge core_clk) disable iff (reset)
        !clear_faults |=> (temp_flags & $past(temp_flags)) == $past(temp_flags))
        else $error("temp flag dropped");
    AST_COMM_HOLD: assert property (@(posedge core_clk) disable iff (reset)
        !clear_faults |=> (comm_flags & $past(comm_flags)) == $past(comm_flags))
        else $error("comm flag dropped");
    AST_STICKY_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
        channel_on_cmd[0] && !discharge_evt[0] |=> !vendor_flags[0][`PMSR_VENDOR_DISCHARGE])
        else $error("sticky not cleared");

    // ************************************************************
    // vendor flags
    // ************************************************************
    AST_DISCHARGE_SET: assert property (@(posedge core_clk) disable iff (reset)
        discharge_evt[0] |=> vendor_flags[0][7]) else $error("discharge lost");
    AST_FAULT1_SET: assert property (@(posedge core_clk) disable iff (reset)
        fault1_evt[0] |=> vendor_flags[0][6]) else $error("fault one lost");
    AST_FAULT0_SET: assert property (@(posedge core_clk) disable iff (reset)
        fault0_evt[0] |=> vendor_flags[0][5]) else $error("fault zero lost");
    AST_SAT_SET: assert property (@(posedge core_clk) disable iff (reset)
        dac_saturated_evt[0] |=> vendor_flags[0][2]) else $error("saturated lost");
    AST_WATCHDOG_SET: assert property (@(posedge core_clk) disable iff (reset)
        watchdog_evt |=> vendor_flags[0][0]) else $error("watchdog lost");
    AST_LIVE_NOT_STORED: assert property (@(posedge core_clk) disable iff (reset)
        (vendor_flags[0] & ~`PMSR_STICKY_MASK) == 8'h00)
        else $error("live bit stored");
    AST_ALERT_SET: assert property (@(posedge core_clk) disable iff (reset)
        (vendor_flags[0] & `PMSR_ALERT_MASK) != 8'h00 |=> !alert_out_n)
        else $error("alert missing");

    // ************************************************************
    // read path
    // ************************************************************
    AST_SERVO_VIEW: assert property (@(posedge core_clk) disable iff (reset)
        read_sel == PMSR_SEL_VENDOR && servo_reached[page] |=> read_data[4])
        else $error("servo not shown");
    AST_DAC_VIEW: assert property (@(posedge core_clk) disable iff (reset)
        read_sel == PMSR_SEL_VENDOR && dac_drive_pin[page] |=> read_data[3])
        else $error("dac not shown");
    AST_VINEN_VIEW: assert property (@(posedge core_clk) disable iff (reset)
        read_sel == PMSR_SEL_VENDOR && vinen_faulted_off |=> read_data[1])
        else $error("vinen not shown");
    AST_GLOBAL_WD: assert property (@(posedge core_clk) disable iff (reset)
        read_sel == PMSR_SEL_VENDOR && vendor_flags[0][0] |=> read_data[0])
        else $error("watchdog not shown");
    AST_INPUT_READ: assert property (@(posedge core_clk) disable iff (reset)
        read_sel == PMSR_SEL_INPUT |=> read_data == {8'h00, $past(input_flags)})
        else $error("input read wrong");
    AST_TEMP_FLAGS_READ: assert property (@(posedge core_clk) disable iff (reset)
        read_sel == PMSR_SEL_TEMP |=> read_data == {8'h00, $past(temp_flags)})
        else $error("temp read wrong");
    AST_COMM_READ: assert property (@(posedge core_clk) disable iff (reset)
        read_sel == PMSR_SEL_COMM |=> read_data == {8'h00, $past(comm_flags)})
        else $error("comm read wrong");
    AST_TEMP_READ: assert property (@(posedge core_clk) disable iff (reset)
        temp_valid ##1 read_sel == PMSR_SEL_TEMP_READ && !temp_valid
        |=> read_data == $past(temp_sample, 2)) else $error("temp stale");
    AST_VOUT_READ: assert property (@(posedge core_clk) disable iff (reset)
        vout_valid && vout_channel == PAGE_W'(1) ##1
        read_sel == PMSR_SEL_VOUT && page == PAGE_W'(1) && !vout_valid
        |=> read_data == $past(vout_sample, 2)) else $error("vout stale");

    // ************************************************************
    // resolution select
    // ************************************************************
    AST_HIRES_EVEN: assert property (@(posedge core_clk) disable iff (reset)
        !hires_active[0]) else $error("even channel hires");
    AST_HIRES_ODD: assert property (@(posedge core_clk) disable iff (reset)
        hires_cfg[1] |-> hires_active[1]) else $error("odd channel not hires");
endmodule

// ---- rtl/pmsr_cfg.svh ----
// constants for the power monitor status register bank
// Notes on behaviour
// - input status bits 7..3: ov fault, ov warn, uv warn, uv fault, off for low input.
// - input status bits 2..0 always read zero.
// - temperature status bits 7..4: ot fault, ot warn, ut warn, ut fault.
// - temperature status bits 3..0 always read zero.
// - comm status bit 7 on bad command, bit 6 on bad data.
// - extra byte before stop sets comm bit 5 unless it is a matching check byte.
// - memory fault sets comm bit 4; clear-faults clears it; host retries access.
// - any other malformed transaction sets comm bit 1.
// - comm status bits 3, 2 and 0 always read zero.
// - sticky vendor bits hold until clear-faults or channel commanded on.
// - any set alert-capable vendor bit drives alert output low.
// - global vendor bits are unpaged; others follow the selected page.
// - vendor bit 7: per-page sticky discharge fault, raises alert.
// - vendor bits 6 and 5: per-page sticky fault input one and zero events.
// - vendor bits 4 and 3: per-page live servo reached and dac driving.
// - vendor bit 2: per-page sticky dac saturated, no alert.
// - vendor bit 1: global live input-enable off due to output fault.
// - vendor bit 0: global sticky watchdog fault with alert.
// - input voltage reading returns latest 16-bit sample.
// - output reading latest 16-bit sample; odd hi-res channels use other format.
// - junction temperature reading returns latest 16-bit sample.
// - protocol revision code is a fixed read-only byte.
// - hi-res select honoured on odd channels only; even channels stay low-res.
`ifndef PMSR_CFG_SVH
`define PMSR_CFG_SVH
`define PMSR_VENDOR_DISCHARGE   7
`define PMSR_VENDOR_FAULT1      6
`define PMSR_VENDOR_FAULT0      5
`define PMSR_VENDOR_SERVO       4
`define PMSR_VENDOR_DAC         3
`define PMSR_VENDOR_SATURATED   2
`define PMSR_VENDOR_VINEN_OFF   1
`define PMSR_VENDOR_WATCHDOG    0
`define PMSR_STICKY_MASK        8'he5
`define PMSR_ALERT_MASK         8'he1
`define PMSR_GLOBAL_MASK        8'h03
`define PMSR_REVISION_CODE      8'h5a  // arbitrary value, stands in for the real code
`define PMSR_FLAG_RESET         8'h00
`define PMSR_WORD_RESET         16'h0000
`endif

// ---- rtl/pmsr_pkg.sv ----
// types for the power monitor status register bank
package pmsr_pkg;
    typedef enum logic [2:0] {
        PMSR_SEL_INPUT,
        PMSR_SEL_TEMP,
        PMSR_SEL_COMM,
        PMSR_SEL_VENDOR,
        PMSR_SEL_VIN,
        PMSR_SEL_VOUT,
        PMSR_SEL_TEMP_READ,
        PMSR_SEL_REVISION
    } pmsr_sel_t;
endpackage

// ---- verif/pmsr_host_model.sv ----
// host reader model for the status register bank
module pmsr_host_model (
    // clock
    input  wire logic                core_clk,
    // request from bench
    input  wire logic                req,
    input  wire pmsr_pkg::pmsr_sel_t req_sel,
    input  wire logic [2:0]          req_page,
    // bank read port
    output pmsr_pkg::pmsr_sel_t      read_sel,
    output logic [2:0]               page,
    input  wire logic [15:0]         read_data,
    // answer
    output logic                     rsp_valid,
    output logic [15:0]              rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import pmsr_pkg::*;
    // reads only, page scrambled while idle
    assign read_sel = req_sel;
    assign page     = req ? req_page : ~req_page;
    assign rsp_data = read_data;
    always @(posedge core_clk) begin
        rsp_valid <= req;
    end
endmodule

// ---- verif/pmsr_status_regs_tb.sv ----
// self-checking bench for the status register bank
`include "pmsr_cfg.svh"
`define CHK(g, e) chk(16'(g), 16'(e))
module pmsr_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pmsr_pkg::*;
    logic        core_clk, reset, req, clear_faults, bad_command, bad_data, extra_byte;
    logic        extra_byte_pec_ok, memory_fault, malformed_txn, vinen_faulted_off;
    logic        watchdog_evt, vin_valid, vout_valid, temp_valid, alert_out_n, rsp_valid;
    logic [2:0]  page, req_page, vout_channel;
    logic [4:0]  input_evt;
    logic [3:0]  temp_evt;
    logic [7:0]  channel_on_cmd, discharge_evt, fault1_evt, fault0_evt, servo_reached;
    logic [7:0]  dac_drive_pin, dac_saturated_evt, hires_cfg, hires_active;
    logic [15:0] read_data, rsp_data, vin_sample, vout_sample, temp_sample, w, wo;
    pmsr_sel_t   read_sel, req_sel;
    logic [15:0] q[$];
    int          errors, n_tests;
    logic [31:0] rnd;

    pmsr_status_regs #(.CHANNELS(8), .PAGE_W(3)) i_pmsr_status_regs (.*);
    pmsr_host_model i_pmsr_host_model (.*);

    always #25 core_clk = ~core_clk;

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(logic [15:0] g, logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic go;
        @(posedge core_clk);
        #1 req = 1'b0;
    endtask
    task automatic rd(pmsr_sel_t s, logic [2:0] p, logic [15:0] e);
        @(posedge core_clk);
        #1 req_sel = s;
        req_page = p;
        req = 1'b1;
        q.push_back(e);
    endtask
    task automatic clr;
        go;
        clear_faults = 1'b1;
        go;
        clear_faults = 1'b0;
    endtask
    task automatic wrap_up;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // monitor: answers come in request order
    always @(posedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            if (q.size() == 0) begin
                errors++;
            end else begin
                `CHK(rsp_data, q.pop_front());
            end
        end
    end

    initial begin
        #1000000;
        errors++;
        wrap_up;
    end

    initial begin
        {core_clk, req, clear_faults, bad_command, bad_data, extra_byte, extra_byte_pec_ok} = '0;
        {memory_fault, malformed_txn, vinen_faulted_off, watchdog_evt, vin_valid} = '0;
        {vout_valid, temp_valid, vout_channel, req_page, input_evt, temp_evt} = '0;
        {channel_on_cmd, discharge_evt, fault1_evt, fault0_evt, servo_reached} = '0;
        {dac_drive_pin, dac_saturated_evt, hires_cfg, vin_sample, vout_sample, temp_sample} = '0;
        req_sel = PMSR_SEL_INPUT;
        reset = 1'b1;
        rnd = 32'hc1d59539;
        errors = 0;
        n_tests = 0;
        repeat (4) @(posedge core_clk);
        #1 reset = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(pmsr_sel_t'(i), 3'(i), (i == 7) ? 16'(`PMSR_REVISION_CODE) : 16'h0);
        end
        `CHK(alert_out_n, 1);
        for (int i = 0; i < 5; i++) begin
            go;
            input_evt = 5'(1 << i);
            temp_evt = 4'(1 << i);
            go;
            {input_evt, temp_evt} = '0;
            rd(PMSR_SEL_INPUT, 3'(i), 16'(8'(8'h08 << i)));
            rd(PMSR_SEL_TEMP, 3'(i), 16'(8'(8'h10 << i)));
            clr;
        end
        go;
        {bad_command, bad_data, extra_byte, memory_fault, malformed_txn} = '1;
        go;
        {bad_command, bad_data, extra_byte, memory_fault, malformed_txn} = '0;
        rd(PMSR_SEL_COMM, 0, 16'h00f2);
        rd(PMSR_SEL_COMM, 0, 16'h00f2);
        clr;
        rd(PMSR_SEL_COMM, 0, 16'h0000);
        go;
        {extra_byte, extra_byte_pec_ok} = '1;
        go;
        {extra_byte, extra_byte_pec_ok} = '0;
        rd(PMSR_SEL_COMM, 0, 16'h0000);
        go;
        {discharge_evt, fault1_evt, fault0_evt, dac_saturated_evt} = {4{8'h08}};
        {servo_reached, dac_drive_pin, vinen_faulted_off} = {8'h08, 8'h08, 1'b1};
        go;
        {discharge_evt, fault1_evt, fault0_evt, dac_saturated_evt} = '0;
        rd(PMSR_SEL_VENDOR, 3, 16'h00fe);
        rd(PMSR_SEL_VENDOR, 2, 16'h0002);
        go;
        `CHK(alert_out_n, 0);
        {servo_reached, dac_drive_pin, vinen_faulted_off} = '0;
        channel_on_cmd = 8'h08;
        go;
        channel_on_cmd = 8'h00;
        rd(PMSR_SEL_VENDOR, 3, 16'h0000);
        go;
        dac_saturated_evt = 8'h20;
        go;
        dac_saturated_evt = 8'h00;
        rd(PMSR_SEL_VENDOR, 5, 16'h0004);
        go;
        go;
        `CHK(alert_out_n, 1);
        watchdog_evt = 1'b1;
        go;
        watchdog_evt = 1'b0;
        rd(PMSR_SEL_VENDOR, 6, 16'h0001);
        go;
        go;
        `CHK(alert_out_n, 0);
        clr;
        rd(PMSR_SEL_VENDOR, 5, 16'h0000);
        repeat (3) begin
            rnd = lfsr(rnd);
            w = rnd[15:0];
            wo = rnd[31:16];
            go;
            {vin_valid, temp_valid, vout_valid, vout_channel} = {3'b111, 3'd1};
            {vin_sample, temp_sample, vout_sample, hires_cfg} = {w, ~w, wo, rnd[7:0]};
            go;
            {vin_valid, temp_valid, vout_valid, vin_sample, vout_sample} = '0;
            rd(PMSR_SEL_VIN, 0, w);
            rd(PMSR_SEL_TEMP_READ, 0, ~w);
            rd(PMSR_SEL_VOUT, 1, wo);
            `CHK(hires_active, hires_cfg & 8'haa);
        end
        go;
        for (int i = 0; i < 10 && q.size() > 0; i++) begin
            go;
        end
        if (q.size() != 0) begin
            errors++;
        end
        wrap_up;
    end
endmodule
